// [hw/wdprc_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "wdprc_map.svh"

// Functional notes
// - watchdog control register at 8FH, fixed bits
// - watchdog counts only while enabled
// - divider chain, selected tap sets interval
// - time-out while enabled resets system
// - every reset disables the watchdog
// - every reset zeroes counter and prescaler
// - restart clears timer, prescaler, bit next cycle
// - idle-run bit gates counting in idle
// - select code maps to ratio 2..256
// - time-out is osc x 2^14 x ratio x 12
// - oscillator divided by two internally
// - doze bit stops processor clock only
// - interrupt or reset ends idle
// - deep-sleep bit stops all clocks, oscillator
// - only reset ends deep sleep
// - cold-boot flag bit 4, power-on sets
// - two user flags, written by software, cleared by every reset
// - reset pin sampled at state5 phase2
// - reset pin filtered against glitches
// - reset loads ports, stack, other registers
module wdprc_top
#(
	parameter int TIMER_BITS = `WDPRC_TIMER_BITS
)
(
	input  wire logic                    clk,
	input  wire logic                    rst,
	input  wire logic                    ce,
	input  wire logic [7:0]              reg_addr,
	input  wire logic [7:0]              reg_wdata,
	input  wire logic                    reg_wr,
	input  wire logic                    reg_rd,
	output var  logic [7:0]              reg_rdata,
	input  wire logic                    reset_pin,
	input  wire logic                    irq_wake,
	output var  wdprc_pkg::wdprc_clk_type  clk_ctl,
	output var  wdprc_pkg::wdprc_load_type load_vals,
	output var  logic                    sys_reset,
	output var  logic                    wdt_fired
);

	// prescaler tap for each select code
	function automatic logic [`WDPRC_PRE_BITS-1:0] tap_mask
	(
		input logic [2:0] sel
	);
		unique case (sel)
			3'h0: tap_mask = 8'h01;
			3'h2: tap_mask = 8'h03;
			3'h1: tap_mask = 8'h07;
			3'h3: tap_mask = 8'h0F;
			3'h4: tap_mask = 8'h1F;
			3'h5: tap_mask = 8'h3F;
			3'h6: tap_mask = 8'h7F;
			3'h7: tap_mask = 8'hFF;
		endcase
	endfunction

	wdprc_pkg::wdprc_mode_type    mode;
	wdprc_pkg::wdprc_mode_type    next_mode;
	logic [3:0]                   osc_slot;
	logic                         mc_tick;
	logic                         sample_tick;
	logic                         pin_meta;
	logic                         pin_sync;
	logic [`WDPRC_PIN_HOLD_MC-1:0] pin_hist;
	logic                         pin_reset;
	logic                         wdt_en;
	logic                         wdt_restart;
	logic                         wdt_idle_run;
	logic [2:0]                   wdt_sel;
	logic [`WDPRC_PRE_BITS-1:0]   prescaler;
	logic [TIMER_BITS-1:0]        timer;
	logic [`WDPRC_PRE_BITS-1:0]   mask;
	logic                         wdt_count;
	logic                         pre_done;
	logic                         timeout;
	logic [1:0]                   wdt_hold;
	logic                         int_reset;
	logic                         any_reset;
	logic                         cold_boot_flag;
	logic                         user_flag_1;
	logic                         user_flag_0;
	logic                         wr_wdt;
	logic                         wr_pwr;
	logic [7:0]                   wdt_control_reg;
	logic [7:0]                   power_control_reg;

	assign wr_wdt = reg_wr && (reg_addr == `WDPRC_WDT_ADDR);
	assign wr_pwr = reg_wr && (reg_addr == `WDPRC_PWR_ADDR);

	// machine cycle of twelve oscillator clocks, six states of two phases
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			osc_slot <= 4'h0;
		end
		else if (ce)
		begin
			if (osc_slot == `WDPRC_OSC_PER_MC - 4'h1)
			begin
				osc_slot <= 4'h0;
			end
			else
			begin
				osc_slot <= osc_slot + 4'h1;
			end
		end
	end

	assign mc_tick     = ce && (osc_slot == `WDPRC_OSC_PER_MC - 4'h1);
	assign sample_tick = ce && (osc_slot == `WDPRC_SAMPLE_SLOT);

	// reset pin synchroniser
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			pin_meta <= 1'b0;
			pin_sync <= 1'b0;
		end
		else if (ce)
		begin
			pin_meta <= reset_pin;
			pin_sync <= pin_meta;
		end
	end

	// one sample per machine cycle; all recent samples must be high
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			pin_hist <= '0;
		end
		else if (sample_tick)
		begin
			pin_hist <= {pin_hist[`WDPRC_PIN_HOLD_MC-2:0], pin_sync};
		end
	end

	assign pin_reset = &pin_hist;

	// watchdog reset stretched over two machine cycles
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			wdt_hold <= 2'h0;
		end
		else if (ce)
		begin
			if (timeout)
			begin
				wdt_hold <= `WDPRC_WDT_RST_MC;
			end
			else if (mc_tick && wdt_hold != 2'h0)
			begin
				wdt_hold <= wdt_hold - 2'h1;
			end
		end
	end

	assign int_reset = pin_reset || (wdt_hold != 2'h0);
	assign any_reset = rst || int_reset;

	// watchdog control register
	always_ff @(posedge clk)
	begin
		if (any_reset)
		begin
			wdt_en       <= 1'(`WDPRC_WDT_RESET >> `WDPRC_WDT_EN_POS);
			wdt_restart  <= 1'b0;
			wdt_idle_run <= 1'b0;
			wdt_sel      <= 3'h0;
		end
		else if (ce)
		begin
			if (wr_wdt)
			begin
				wdt_en       <= reg_wdata[`WDPRC_WDT_EN_POS];
				wdt_restart  <= reg_wdata[`WDPRC_WDT_RESTART_POS];
				wdt_idle_run <= reg_wdata[`WDPRC_WDT_IDLE_POS];
				wdt_sel      <= reg_wdata[`WDPRC_WDT_SEL_MSB:`WDPRC_WDT_SEL_LSB];
			end
			else if (mc_tick)
			begin
				wdt_restart <= 1'b0;
			end
		end
	end

	// counting stops outside run, or in idle unless allowed
	assign wdt_count = wdt_en
		&& (mode == wdprc_pkg::WDPRC_RUN
		|| (mode == wdprc_pkg::WDPRC_IDLE && wdt_idle_run));

	assign mask     = tap_mask(wdt_sel);
	assign pre_done = (prescaler & mask) == mask;
	assign timeout  = mc_tick && wdt_count && !wdt_restart
		&& pre_done && (&timer);

	// prescaler of machine cycles and 14-bit timer
	always_ff @(posedge clk)
	begin
		if (any_reset)
		begin
			prescaler <= '0;
			timer     <= '0;
		end
		else if (mc_tick)
		begin
			if (wdt_restart)
			begin
				prescaler <= '0;
				timer     <= '0;
			end
			else if (wdt_count)
			begin
				prescaler <= prescaler + 8'h01;
				if (pre_done)
				begin
					timer <= timer + {{(TIMER_BITS-1){1'b0}}, 1'b1};
				end
			end
		end
	end

	// time-out flag pulse
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			wdt_fired <= 1'b0;
		end
		else if (ce)
		begin
			wdt_fired <= timeout;
		end
	end

	// power mode sequencing
	always_comb
	begin
		next_mode = mode;
		unique case (mode)
			wdprc_pkg::WDPRC_RESET:
			begin
				next_mode = wdprc_pkg::WDPRC_RUN;
			end
			wdprc_pkg::WDPRC_RUN:
			begin
				if (wr_pwr && reg_wdata[`WDPRC_PWR_DEEP_POS])
				begin
					next_mode = wdprc_pkg::WDPRC_DOWN;
				end
				else if (wr_pwr && reg_wdata[`WDPRC_PWR_DOZE_POS])
				begin
					next_mode = wdprc_pkg::WDPRC_IDLE;
				end
			end
			wdprc_pkg::WDPRC_IDLE:
			begin
				if (irq_wake)
				begin
					next_mode = wdprc_pkg::WDPRC_RUN;
				end
			end
			wdprc_pkg::WDPRC_DOWN:
			begin
				next_mode = wdprc_pkg::WDPRC_DOWN;
			end
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (any_reset)
		begin
			mode <= wdprc_pkg::WDPRC_RESET;
		end
		else if (ce)
		begin
			mode <= next_mode;
		end
	end

	// cold-boot flag: power-on reset sets it, other resets keep it, software writes it
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			cold_boot_flag <= 1'b1;
		end
		else if (ce && wr_pwr)
		begin
			cold_boot_flag <= reg_wdata[`WDPRC_PWR_COLD_POS];
		end
	end

	// user flags
	always_ff @(posedge clk)
	begin
		if (any_reset)
		begin
			user_flag_1 <= 1'b0;
			user_flag_0 <= 1'b0;
		end
		else if (ce && wr_pwr)
		begin
			user_flag_1 <= reg_wdata[`WDPRC_PWR_UF1_POS];
			user_flag_0 <= reg_wdata[`WDPRC_PWR_UF0_POS];
		end
	end

	// register images
	always_comb
	begin
		wdt_control_reg = 8'h00;
		wdt_control_reg[`WDPRC_WDT_EN_POS]      = wdt_en;
		wdt_control_reg[`WDPRC_WDT_RESTART_POS] = wdt_restart;
		wdt_control_reg[`WDPRC_WDT_IDLE_POS]    = wdt_idle_run;
		wdt_control_reg[`WDPRC_WDT_SEL_MSB:`WDPRC_WDT_SEL_LSB] = wdt_sel;
	end

	always_comb
	begin
		power_control_reg = 8'h00;
		power_control_reg[`WDPRC_PWR_COLD_POS] = cold_boot_flag;
		power_control_reg[`WDPRC_PWR_UF1_POS]  = user_flag_1;
		power_control_reg[`WDPRC_PWR_UF0_POS]  = user_flag_0;
		power_control_reg[`WDPRC_PWR_DEEP_POS] =
			(mode == wdprc_pkg::WDPRC_DOWN);
		power_control_reg[`WDPRC_PWR_DOZE_POS] =
			(mode == wdprc_pkg::WDPRC_IDLE);
	end

	// read data valid in the cycle after the strobe only
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			reg_rdata <= 8'h00;
		end
		else if (ce)
		begin
			if (reg_rd && reg_addr == `WDPRC_WDT_ADDR)
			begin
				reg_rdata <= wdt_control_reg;
			end
			else if (reg_rd && reg_addr == `WDPRC_PWR_ADDR)
			begin
				reg_rdata <= power_control_reg;
			end
			else
			begin
				reg_rdata <= 8'h00;
			end
		end
	end

	// clock gating outputs; half clock toggles while oscillator runs
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			clk_ctl <= '0;
		end
		else if (ce)
		begin
			clk_ctl.cpu_en    <= (next_mode == wdprc_pkg::WDPRC_RUN)
				&& !int_reset;
			clk_ctl.periph_en <= (next_mode != wdprc_pkg::WDPRC_DOWN);
			clk_ctl.osc_en    <= (next_mode != wdprc_pkg::WDPRC_DOWN);
			if (mode != wdprc_pkg::WDPRC_DOWN)
			begin
				clk_ctl.half_clk <= !clk_ctl.half_clk;
			end
		end
	end

	// system reset level and load values for the rest of the core
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			sys_reset <= 1'b1;
		end
		else if (ce)
		begin
			sys_reset <= int_reset;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			load_vals.port <= `WDPRC_PORT_RESET;
			load_vals.sp   <= `WDPRC_SP_RESET;
			load_vals.sfr  <= `WDPRC_SFR_RESET;
		end
	end

endmodule // wdprc_top

`default_nettype wire

// [inc/wdprc_map.svh]
`ifndef WDPRC_MAP_SVH
`define WDPRC_MAP_SVH

// register addresses in the special-function space
`define WDPRC_PWR_ADDR         8'h87
`define WDPRC_WDT_ADDR         8'h8F

// watchdog control fields
`define WDPRC_WDT_EN_POS       7
`define WDPRC_WDT_RESTART_POS  6
`define WDPRC_WDT_IDLE_POS     5
`define WDPRC_WDT_SEL_MSB      2
`define WDPRC_WDT_SEL_LSB      0

// power control fields
`define WDPRC_PWR_COLD_POS     4
`define WDPRC_PWR_UF1_POS      3
`define WDPRC_PWR_UF0_POS      2
`define WDPRC_PWR_DEEP_POS     1
`define WDPRC_PWR_DOZE_POS     0

// reset values
`define WDPRC_WDT_RESET        8'h00
`define WDPRC_PWR_RESET        8'h00
`define WDPRC_PORT_RESET       8'hFF
`define WDPRC_SP_RESET         8'h07
`define WDPRC_SFR_RESET        8'h00

// timing counts, in oscillator clocks or machine cycles, and counter widths in bits
`define WDPRC_OSC_PER_MC       4'hC
`define WDPRC_SAMPLE_SLOT      4'h9
`define WDPRC_PIN_HOLD_MC      2
`define WDPRC_WDT_RST_MC       2'h2
`define WDPRC_TIMER_BITS       14
`define WDPRC_PRE_BITS         8

`endif

// [inc/wdprc_pkg.sv]
package wdprc_pkg;

	typedef enum logic [1:0]
	{
		WDPRC_RUN   = 2'b00,
		WDPRC_IDLE  = 2'b01,
		WDPRC_DOWN  = 2'b10,
		WDPRC_RESET = 2'b11
	} wdprc_mode_type;

	typedef struct packed
	{
		logic cpu_en;
		logic periph_en;
		logic osc_en;
		logic half_clk;
	} wdprc_clk_type;

	typedef struct packed
	{
		logic [7:0] port;
		logic [7:0] sp;
		logic [7:0] sfr;
	} wdprc_load_type;

endpackage

// [sim/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam int TB = 3;
	logic clk = 1'h0;
	logic rst, reg_wr, reg_rd, irq_wake, reset_pin, sys_reset, wdt_fired;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	wdprc_pkg::wdprc_clk_type clk_ctl;
	wdprc_pkg::wdprc_load_type load_vals;
	int error_cnt = 0;
	int check_count = 0;
	always #5 clk = ~clk;
	wdprc_partner partner_u (.clk(clk), .reset_pin(reset_pin));
	wdprc_top #(.TIMER_BITS(TB)) dut_u (.clk(clk), .rst(rst), .ce(1'h1),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .reset_pin(reset_pin),
		.irq_wake(irq_wake), .clk_ctl(clk_ctl), .load_vals(load_vals),
		.sys_reset(sys_reset), .wdt_fired(wdt_fired));
	task conclude;
		$display("errors %0d checks %0d", error_cnt, check_count);
		if (error_cnt == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge clk);
		reg_wr <= 1'h0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge clk);
		reg_rd <= 1'h0;
		#1 chk({24'h000000, reg_rdata}, {24'h000000, e});
	endtask
	task ctl(input logic [31:0] e);
		chk({28'h0000000, clk_ctl[3:1], 1'h0}, e);
	endtask
	// s: 0 fired, 1 reset high, 2 reset low; must: bound is fatal
	task wt(input int s, input int lim, input logic must, output int n);
		logic hit;
		n = 0;
		hit = 1'h0;
		while (!hit && n < lim)
		begin
			@(negedge clk);
			n++;
			hit = (s == 0 && wdt_fired === 1'h1) ||
				(s == 1 && sys_reset === 1'h1) || (s == 2 && sys_reset === 1'h0);
		end
		if (must && !hit)
		begin
			chk(0, 1);
			conclude();
		end
	endtask
	task t_reset;
		logic h;
		rd(8'h87, 8'h10);
		rd(8'h8F, 8'h00);
		rd(8'h3C, 8'h00);
		chk({8'h00, load_vals}, 32'h00FF0700);
		@(negedge clk);
		h = clk_ctl.half_clk;
		@(negedge clk);
		chk({31'h0, clk_ctl.half_clk}, {31'h0, ~h});
		ctl(32'hE);
	endtask
	task t_regs;
		int n;
		wr(8'h8F, 8'h2F);
		wr(8'h88, 8'hFF);
		rd(8'h8F, 8'h27);
		wr(8'h87, 8'hEC);
		rd(8'h87, 8'h0C);
		wt(1, 300, 1'h0, n);
		chk(n, 300);
		wr(8'h8F, 8'h00);
	endtask
	task t_ratios;
		int n, e;
		for (int k = 0; k < 8; k++)
		begin
			e = 12 * (2 << k) * (1 << TB);
			wr(8'h8F, {5'h10, k[2] ? k[2:0] : {1'h0, k[0], k[1]}});
			wt(0, e + 40, 1'h1, n);
			chk(n > e - 14 && n < e + 14, 1);
			wt(2, 100, 1'h1, n);
			rd(8'h8F, 8'h00);
			rd(8'h87, 8'h00);
		end
	endtask
	task t_restart;
		int n;
		wr(8'h8F, 8'h80);
		repeat (6)
		begin
			wt(1, 60, 1'h0, n);
			chk(n, 60);
			wr(8'h8F, 8'hC0);
		end
		wt(1, 20, 1'h0, n);
		rd(8'h8F, 8'h80);
		wr(8'h8F, 8'h00);
		wt(1, 400, 1'h0, n);
		chk(n, 400);
	endtask
	task t_doze;
		int n;
		wr(8'h8F, 8'hA0);
		wr(8'h87, 8'h01);
		repeat (2) @(negedge clk);
		ctl(32'h6);
		wt(0, 250, 1'h1, n);
		wt(2, 100, 1'h1, n);
		repeat (3) @(negedge clk);
		ctl(32'hE);
		wr(8'h8F, 8'h80);
		wr(8'h87, 8'h01);
		wt(1, 400, 1'h0, n);
		chk(n, 400);
		@(posedge clk);
		irq_wake <= 1'h1;
		repeat (3) @(negedge clk);
		ctl(32'hE);
		wr(8'h8F, 8'h00);
		irq_wake <= 1'h0;
	endtask
	task t_deep;
		int n;
		wr(8'h87, 8'h02);
		repeat (2) @(negedge clk);
		ctl(32'h0);
		@(posedge clk);
		irq_wake <= 1'h1;
		wt(1, 30, 1'h0, n);
		ctl(32'h0);
		irq_wake <= 1'h0;
		partner_u.press(3);
		wt(1, 40, 1'h0, n);
		chk(n, 40);
		partner_u.press(30);
		wt(1, 60, 1'h1, n);
		wt(2, 60, 1'h1, n);
		repeat (3) @(negedge clk);
		ctl(32'hE);
		rd(8'h87, 8'h00);
		@(posedge clk);
		rst <= 1'h1;
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		rd(8'h87, 8'h10);
	endtask
	initial
	begin
		rst = 1'h1;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'h0;
		reg_rd = 1'h0;
		irq_wake = 1'h0;
		repeat (6) @(posedge clk);
		rst <= 1'h0;
		t_reset();
		t_regs();
		t_ratios();
		t_restart();
		t_doze();
		t_deep();
		conclude();
	end
endmodule // testbench
`default_nettype wire

// [sim/wdprc_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module wdprc_checker
(
	input wire logic                      clk,
	input wire logic                      rst,
	input wire logic [7:0]                reg_addr,
	input wire logic                      reg_rd,
	input wire logic [7:0]                reg_rdata,
	input wire logic                      reset_pin,
	input wire logic                      irq_wake,
	input wire wdprc_pkg::wdprc_clk_type  clk_ctl,
	input wire logic                      sys_reset,
	input wire logic                      wdt_fired
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_rd_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data not zero");
	a_wdt_rsvd_zero: assert property ($past(reg_rd) &&
		$past(reg_addr) == 8'h8F |-> !reg_rdata[3]) else $error("bit3 set");
	a_pwr_rsvd_zero: assert property ($past(reg_rd) &&
		$past(reg_addr) == 8'h87 |-> reg_rdata[7:5] == 3'h0)
		else $error("power top bits set");
	a_fire_pulse: assert property (wdt_fired |=> !wdt_fired)
		else $error("fire pulse too long");
	a_fire_reset: assert property (wdt_fired |-> ##[0:1] sys_reset)
		else $error("time-out without reset");
	a_deep_clocks: assert property (!clk_ctl.osc_en |->
		!clk_ctl.cpu_en && !clk_ctl.periph_en) else $error("clock with osc off");
	a_deep_exit: assert property ($rose(clk_ctl.osc_en) |->
		$past(sys_reset) || $past(sys_reset, 2) || $past(sys_reset, 3))
		else $error("deep sleep left without reset");
	a_doze_exit: assert property ($rose(clk_ctl.cpu_en) |-> $past(irq_wake) ||
		$past(irq_wake, 2) || $past(sys_reset) || $past(sys_reset, 2) ||
		$past(sys_reset, 3)) else $error("doze left without cause");
	a_pin_filter: assert property ($rose(sys_reset) && !wdt_fired &&
		!$past(wdt_fired) |-> $past(reset_pin, 4) && $past(reset_pin, 16))
		else $error("reset from short pin pulse");
	c_fire: cover property (wdt_fired);
	c_doze: cover property (clk_ctl.periph_en && !clk_ctl.cpu_en);
	c_deep: cover property (!clk_ctl.osc_en && !sys_reset);
endmodule // wdprc_checker
bind wdprc_top wdprc_checker chk_u (.clk(clk), .rst(rst), .reg_addr(reg_addr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .reset_pin(reset_pin),
	.irq_wake(irq_wake), .clk_ctl(clk_ctl), .sys_reset(sys_reset),
	.wdt_fired(wdt_fired));
`default_nettype wire

// [sim/wdprc_partner.sv]
`timescale 1ns/1ps
`default_nettype none
module wdprc_partner
(
	input  wire logic clk,
	output var  logic reset_pin
);
	// pin rests low, pulled down
	initial reset_pin = 1'h0;
	task automatic press(input int n);
		@(posedge clk);
		reset_pin <= 1'h1;
		repeat (n) @(posedge clk);
		reset_pin <= 1'h0;
	endtask
endmodule // wdprc_partner
`default_nettype wire
